// >>> design/batmon_pkg.sv
package batmon_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 50_000_000;
  localparam int CLK_PER_MS = CLK_HZ / 1000;
  localparam int MEAS_PERIOD_MS = 440;
  localparam int SLEEP_TIMEOUT_MS = 2200;
  localparam int MEAS_CYCLES = MEAS_PERIOD_MS * CLK_PER_MS;
  localparam int SLEEP_CYCLES = SLEEP_TIMEOUT_MS * CLK_PER_MS;
  localparam int TMR_W = 27;

  // ----------------------------------------------------------------
  // Serial link
  // ----------------------------------------------------------------
  // Power-up slave address; the value is arbitrary.
  localparam logic [6:0] SLAVE_ADDR_RST = 7'h48;

  // Word indexes of the two-byte registers; byte address is twice the index,
  // the even byte holds bits 15:8 and the odd byte bits 7:0.
  localparam logic [6:0] WI_STATUS = 7'h00;
  localparam logic [6:0] WI_TEMP = 7'h01;
  localparam logic [6:0] WI_VOLT = 7'h02;
  localparam logic [6:0] WI_CUR = 7'h03;
  localparam logic [6:0] WI_ACR = 7'h04;
  localparam logic [6:0] WI_ADDR = 7'h05;

  // Status/config word bit positions.
  localparam int ST_SLEEP_EN = 0;
  localparam int ST_PIO_DRV = 1;
  localparam int ST_PIO_SENSE = 2;
  localparam int ST_VOLT_INV = 3;
  localparam int ST_ACTIVE = 4;
  localparam logic ST_SLEEP_EN_RST = 1'b0;
  localparam logic ST_PIO_DRV_RST = 1'b0;

  // ----------------------------------------------------------------
  // Result formats
  // ----------------------------------------------------------------
  localparam int RES_LSB = 5;
  localparam logic [11:0] VOLT_RAW_MAX = 12'h3ff;
  localparam logic [15:0] VOLT_SAT = 16'h7fff;
  localparam logic signed [17:0] CUR_RAW_MAX = 18'sh07fff;
  localparam logic signed [17:0] CUR_RAW_MIN = 18'sh38000;
  localparam logic [15:0] CUR_SAT_POS = 16'h7fff;
  localparam logic [15:0] CUR_SAT_NEG = 16'h8000;
  localparam logic [15:0] ACR_MAX = 16'hffff;
  localparam logic [15:0] ACR_MIN = 16'h0000;

  typedef enum logic [6:0] {
    L_IDLE = 7'h01,
    L_ADDR = 7'h02,
    L_AACK = 7'h04,
    L_RX = 7'h08,
    L_WACK = 7'h10,
    L_TX = 7'h20,
    L_RACK = 7'h40
  } link_state_e;

endpackage : batmon_pkg

// >>> design/batmon.sv
`timescale 1ns/100ps

// What this block does
// [R01] Active mode keeps acquiring voltage, temperature, current and charge into result registers.
// [R02] Active mode serves bus reads and writes to every exposed register.
// [R03] Sleep mode stops measuring: no result update, no charge accumulation.
// [R04] Sleep mode still serves current, charge and status/control register accesses.
// [R05] Sleep enabled plus both lines low for the sleep timeout enters sleep.
// [R06] Host never holds both lines low past the sleep timeout in transfers.
// [R07] Voltage result refreshes every 440ms in two's complement form.
// [R08] Voltage is measured against ground from zero up to 4.992V.
// [R09] Voltage is a 10-bit value, 4.88mV per step, in a two-byte register.
// [R10] Voltage above the largest code saturates at 7FFFh, never wraps.
// [R11] First voltage after reset or charge register write is flagged invalid.
// [R12] Signed current, 1.56uV per step, reported in a two-byte register.
// [R13] Each current measurement is added to the charge accumulator register; it is dropped if a host charge write or sleep entry hits its add cycle.
// [R14] Temperature is reported in a two-byte register, 0.125C per step.
// [R15] Device answers a default slave address, then any programmed address.
// [R16] Clock and data inputs are weakly pulled low; open bus reads low.
// [R17] General purpose pin drives only open-drain low and is sensed as input.
// [R18] Sleep with lines never released high stays asleep, accumulating nothing.
// [R19] Temperature result refreshes every 440ms in two's complement form.
// [R20] Current saturates at 7FFFh above and 8000h below full scale.
// [R21] In sleep, either line sensed high returns to active mode.
// [R22] Two-byte results are read atomically, never mixing old and new bytes.
module batmon #(
  parameter logic [batmon_pkg::TMR_W-1:0] MEAS_CYC = batmon_pkg::TMR_W'(batmon_pkg::MEAS_CYCLES),
  parameter logic [batmon_pkg::TMR_W-1:0] SLEEP_CYC = batmon_pkg::TMR_W'(batmon_pkg::SLEEP_CYCLES)
) (
  // System clock and reset
  input wire logic MCLK,
  input wire logic RESET_N,
  // Serial link
  input wire logic LINK_CLK,
  input wire logic SCL_I,
  input wire logic SDA_I,
  output logic SDA_O,
  output logic SDA_OE,
  // General purpose pin
  input wire logic PIO_I,
  output logic PIO_O,
  output logic PIO_OE,
  // Converter results
  input wire logic signed [17:0] CUR_RAW,
  input wire logic CUR_DONE,
  input wire logic [11:0] VOLT_RAW,
  input wire logic [10:0] TEMP_RAW,
  // Power mode
  output logic ACTIVE
);

  // ----------------------------------------------------------------
  // Link domain: reset release and pin synchronisers
  // ----------------------------------------------------------------
  logic lrst_m_ff, lrst_n;
  logic lscl_m_ff, lscl_s_ff, lscl_d_ff;
  logic lsda_m_ff, lsda_s_ff, lsda_d_ff;
  logic ack_m_ff, ack_s_ff, ack_d_ff;
  logic ack_tgl_ff;
  logic [15:0] rdata_ff;

  always_ff @(posedge LINK_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      lrst_m_ff <= 1'b0;
      lrst_n <= 1'b0;
    end else begin
      lrst_m_ff <= 1'b1;
      lrst_n <= lrst_m_ff;
    end
  end

  // A released bus floats low through the pin pulldowns, so reset to low. [R16]
  always_ff @(posedge LINK_CLK or negedge lrst_n) begin
    if (!lrst_n) begin
      lscl_m_ff <= 1'b0;
      lscl_s_ff <= 1'b0;
      lscl_d_ff <= 1'b0;
      lsda_m_ff <= 1'b0;
      lsda_s_ff <= 1'b0;
      lsda_d_ff <= 1'b0;
      ack_m_ff <= 1'b0;
      ack_s_ff <= 1'b0;
      ack_d_ff <= 1'b0;
    end else begin
      lscl_m_ff <= SCL_I;
      lscl_s_ff <= lscl_m_ff;
      lscl_d_ff <= lscl_s_ff;
      lsda_m_ff <= SDA_I;
      lsda_s_ff <= lsda_m_ff;
      lsda_d_ff <= lsda_s_ff;
      ack_m_ff <= ack_tgl_ff;
      ack_s_ff <= ack_m_ff;
      ack_d_ff <= ack_s_ff;
    end
  end

  logic start_c, stop_c, rise_c, fall_c, ack_evt_c;
  assign start_c = lscl_s_ff & lscl_d_ff & lsda_d_ff & ~lsda_s_ff;
  assign stop_c = lscl_s_ff & lscl_d_ff & ~lsda_d_ff & lsda_s_ff;
  assign rise_c = lscl_s_ff & ~lscl_d_ff;
  assign fall_c = ~lscl_s_ff & lscl_d_ff;
  assign ack_evt_c = ack_s_ff ^ ack_d_ff;

  // ----------------------------------------------------------------
  // Link domain: slave state machine
  // ----------------------------------------------------------------
  batmon_pkg::link_state_e lst_ff;
  logic [7:0] shift_ff, ptr_ff, hold_ff;
  logic [3:0] bitcnt_ff;
  logic rw_ff, first_ff, drv_ff, sda_oe_ff;
  logic [6:0] slave_addr_ff;
  logic req_tgl_ff, req_wr_ff;
  logic [6:0] req_idx_ff;
  logic [15:0] req_wdata_ff, rword_ff;
  logic [7:0] rx_byte_c, tx_byte_c;
  logic [15:0] tx_word_c;

  assign rx_byte_c = {shift_ff[6:0], lsda_s_ff};
  assign tx_word_c = (ptr_ff[7:1] == batmon_pkg::WI_ADDR) ? {9'h000, slave_addr_ff} : rword_ff;
  assign tx_byte_c = ptr_ff[0] ? tx_word_c[7:0] : tx_word_c[15:8];

  // The whole word is fetched once at its high byte, so both bytes match. [R22]
  always_ff @(posedge LINK_CLK or negedge lrst_n) begin
    if (!lrst_n) begin
      rword_ff <= 16'h0000;
    end else if (ack_evt_c) begin
      rword_ff <= rdata_ff;
    end
  end

  always_ff @(posedge LINK_CLK or negedge lrst_n) begin
    if (!lrst_n) begin
      lst_ff <= batmon_pkg::L_IDLE;
      shift_ff <= 8'h00;
      ptr_ff <= 8'h00;
      hold_ff <= 8'h00;
      bitcnt_ff <= 4'h0;
      rw_ff <= 1'b0;
      first_ff <= 1'b0;
      drv_ff <= 1'b0;
      sda_oe_ff <= 1'b0;
      slave_addr_ff <= batmon_pkg::SLAVE_ADDR_RST;
      req_tgl_ff <= 1'b0;
      req_wr_ff <= 1'b0;
      req_idx_ff <= 7'h00;
      req_wdata_ff <= 16'h0000;
    end else if (start_c) begin
      lst_ff <= batmon_pkg::L_ADDR;
      bitcnt_ff <= 4'h0;
      first_ff <= 1'b1;
      drv_ff <= 1'b0;
      sda_oe_ff <= 1'b0;
    end else if (stop_c) begin
      lst_ff <= batmon_pkg::L_IDLE;
      drv_ff <= 1'b0;
      sda_oe_ff <= 1'b0;
    end else begin
      unique case (lst_ff)
        batmon_pkg::L_IDLE: begin
          sda_oe_ff <= 1'b0;
        end
        batmon_pkg::L_ADDR: begin
          if (rise_c) begin
            shift_ff <= rx_byte_c;
            bitcnt_ff <= bitcnt_ff + 4'h1;
            if (bitcnt_ff == 4'h7) begin
              if (rx_byte_c[7:1] == slave_addr_ff) begin // [R15]
                lst_ff <= batmon_pkg::L_AACK;
                rw_ff <= rx_byte_c[0];
                if (rx_byte_c[0]) begin
                  req_tgl_ff <= ~req_tgl_ff;
                  req_wr_ff <= 1'b0;
                  req_idx_ff <= ptr_ff[7:1];
                end
              end else begin
                lst_ff <= batmon_pkg::L_IDLE;
              end
            end
          end
        end
        batmon_pkg::L_AACK, batmon_pkg::L_WACK: begin
          if (fall_c && !drv_ff) begin
            drv_ff <= 1'b1;
            sda_oe_ff <= 1'b1;
          end else if (fall_c) begin
            drv_ff <= 1'b0;
            bitcnt_ff <= 4'h0;
            if (lst_ff == batmon_pkg::L_AACK && rw_ff) begin
              lst_ff <= batmon_pkg::L_TX;
              sda_oe_ff <= ~tx_byte_c[7];
              shift_ff <= {tx_byte_c[6:0], 1'b0};
              bitcnt_ff <= 4'h1;
            end else begin
              lst_ff <= batmon_pkg::L_RX;
              sda_oe_ff <= 1'b0;
            end
          end
        end
        batmon_pkg::L_RX: begin
          if (rise_c) begin
            shift_ff <= rx_byte_c;
            bitcnt_ff <= bitcnt_ff + 4'h1;
            if (bitcnt_ff == 4'h7) begin
              lst_ff <= batmon_pkg::L_WACK;
              if (first_ff) begin
                first_ff <= 1'b0;
                ptr_ff <= rx_byte_c;
              end else begin
                ptr_ff <= ptr_ff + 8'h01;
                if (!ptr_ff[0]) begin
                  hold_ff <= rx_byte_c;
                end else if (ptr_ff[7:1] == batmon_pkg::WI_ADDR) begin
                  slave_addr_ff <= rx_byte_c[6:0]; // [R15]
                end else begin
                  req_tgl_ff <= ~req_tgl_ff; // [R02]
                  req_wr_ff <= 1'b1;
                  req_idx_ff <= ptr_ff[7:1];
                  req_wdata_ff <= {hold_ff, rx_byte_c};
                end
              end
            end
          end
        end
        batmon_pkg::L_TX: begin
          if (fall_c && bitcnt_ff == 4'h8) begin
            lst_ff <= batmon_pkg::L_RACK;
            sda_oe_ff <= 1'b0;
            drv_ff <= 1'b0;
          end else if (fall_c) begin
            sda_oe_ff <= ~shift_ff[7];
            shift_ff <= {shift_ff[6:0], 1'b0};
            bitcnt_ff <= bitcnt_ff + 4'h1;
          end
        end
        batmon_pkg::L_RACK: begin
          if (rise_c && lsda_s_ff) begin
            lst_ff <= batmon_pkg::L_IDLE;
          end else if (rise_c) begin
            drv_ff <= 1'b1;
            ptr_ff <= ptr_ff + 8'h01;
            if (ptr_ff[0]) begin
              req_tgl_ff <= ~req_tgl_ff;
              req_wr_ff <= 1'b0;
              req_idx_ff <= ptr_ff[7:1] + 7'h01;
            end
          end else if (fall_c && drv_ff) begin
            drv_ff <= 1'b0;
            lst_ff <= batmon_pkg::L_TX;
            sda_oe_ff <= ~tx_byte_c[7];
            shift_ff <= {tx_byte_c[6:0], 1'b0};
            bitcnt_ff <= 4'h1;
          end
        end
      endcase
    end
  end

  always_ff @(posedge LINK_CLK or negedge lrst_n) begin
    if (!lrst_n) begin
      SDA_O <= 1'b0;
      SDA_OE <= 1'b0;
    end else begin
      SDA_O <= 1'b0;
      SDA_OE <= sda_oe_ff;
    end
  end

  sequence s_fetch_req;
    $changed(req_tgl_ff) && !req_wr_ff;
  endsequence

  sequence s_fetch_back;
    ##[1:12] ack_evt_c;
  endsequence

  AST_FETCH_TURNAROUND: assert property (@(posedge LINK_CLK) disable iff (!lrst_n) // [R22]
    s_fetch_req |-> s_fetch_back)
    else $error("Register fetch not answered in time.");

  AST_ADDR_NO_ACK: assert property (@(posedge LINK_CLK) disable iff (!lrst_n) // [R15]
    (lst_ff == batmon_pkg::L_ADDR) && rise_c && bitcnt_ff == 4'h7 && rx_byte_c[7:1] != slave_addr_ff
    |=> lst_ff == batmon_pkg::L_IDLE ##1 !SDA_OE)
    else $error("Foreign address was not ignored.");

  // ----------------------------------------------------------------
  // System domain: synchronisers and register access
  // ----------------------------------------------------------------
  logic rq_m_ff, rq_s_ff, rq_d_ff;
  logic bscl_m_ff, bscl_s_ff, bsda_m_ff, bsda_s_ff, pio_m_ff, pio_s_ff;
  logic active_ff, sleep_en_ff, pio_drv_ff, vpend_ff, vinv_ff;
  logic [15:0] temp_ff, volt_ff, cur_ff, acr_ff;
  logic req_evt_c, acr_wr_c, st_wr_c, bus_low_c;

  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      rq_m_ff <= 1'b0;
      rq_s_ff <= 1'b0;
      rq_d_ff <= 1'b0;
      bscl_m_ff <= 1'b0;
      bscl_s_ff <= 1'b0;
      bsda_m_ff <= 1'b0;
      bsda_s_ff <= 1'b0;
      pio_m_ff <= 1'b0;
      pio_s_ff <= 1'b0;
    end else begin
      rq_m_ff <= req_tgl_ff;
      rq_s_ff <= rq_m_ff;
      rq_d_ff <= rq_s_ff;
      bscl_m_ff <= SCL_I;
      bscl_s_ff <= bscl_m_ff;
      bsda_m_ff <= SDA_I;
      bsda_s_ff <= bsda_m_ff;
      pio_m_ff <= PIO_I; // [R17]
      pio_s_ff <= pio_m_ff;
    end
  end

  assign req_evt_c = rq_s_ff ^ rq_d_ff;
  assign acr_wr_c = req_evt_c && req_wr_ff && req_idx_ff == batmon_pkg::WI_ACR; // [R04]
  assign st_wr_c = req_evt_c && req_wr_ff && req_idx_ff == batmon_pkg::WI_STATUS; // [R04]
  assign bus_low_c = ~bscl_s_ff & ~bsda_s_ff;

  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      rdata_ff <= 16'h0000;
      ack_tgl_ff <= 1'b0;
    end else if (req_evt_c && !req_wr_ff) begin
      ack_tgl_ff <= ~ack_tgl_ff; // [R02]
      unique case (req_idx_ff)
        batmon_pkg::WI_STATUS: rdata_ff <= {11'h000, active_ff, vinv_ff, pio_s_ff, pio_drv_ff, sleep_en_ff};
        batmon_pkg::WI_TEMP: rdata_ff <= temp_ff;
        batmon_pkg::WI_VOLT: rdata_ff <= volt_ff;
        batmon_pkg::WI_CUR: rdata_ff <= cur_ff;
        batmon_pkg::WI_ACR: rdata_ff <= acr_ff;
        default: rdata_ff <= 16'h0000;
      endcase
    end
  end

  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      sleep_en_ff <= batmon_pkg::ST_SLEEP_EN_RST;
      pio_drv_ff <= batmon_pkg::ST_PIO_DRV_RST;
    end else if (st_wr_c) begin
      sleep_en_ff <= req_wdata_ff[batmon_pkg::ST_SLEEP_EN];
      pio_drv_ff <= req_wdata_ff[batmon_pkg::ST_PIO_DRV];
    end
  end

  // The pin can only be pulled low; its output value is never high. [R17]
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      PIO_O <= 1'b0;
      PIO_OE <= 1'b0;
      ACTIVE <= 1'b1;
    end else begin
      PIO_O <= 1'b0;
      PIO_OE <= pio_drv_ff;
      ACTIVE <= active_ff;
    end
  end

  // ----------------------------------------------------------------
  // Power modes
  // ----------------------------------------------------------------
  logic [batmon_pkg::TMR_W-1:0] slp_cnt_ff, tb_cnt_ff;
  logic tick_ff;

  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      active_ff <= 1'b1;
      slp_cnt_ff <= '0;
    end else if (!active_ff) begin
      slp_cnt_ff <= '0;
      if (!bus_low_c) begin
        active_ff <= 1'b1; // [R21]
      end
    end else if (sleep_en_ff && bus_low_c) begin
      slp_cnt_ff <= slp_cnt_ff + 1'b1;
      if (slp_cnt_ff == SLEEP_CYC - 1'b1) begin
        active_ff <= 1'b0; // [R05]
        slp_cnt_ff <= '0;
      end
    end else begin
      slp_cnt_ff <= '0;
    end
  end

  // The timebase halts in sleep so no conversion is scheduled. [R03]
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      tb_cnt_ff <= '0;
      tick_ff <= 1'b0;
    end else begin
      tick_ff <= 1'b0;
      if (active_ff) begin
        tb_cnt_ff <= tb_cnt_ff + 1'b1;
        if (tb_cnt_ff == MEAS_CYC - 1'b1) begin
          tb_cnt_ff <= '0;
          tick_ff <= 1'b1; // [R07] [R19]
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Measurement results
  // ----------------------------------------------------------------
  logic [15:0] cur_sat_c;
  logic signed [17:0] acr_sum_c;

  assign cur_sat_c = (CUR_RAW > batmon_pkg::CUR_RAW_MAX) ? batmon_pkg::CUR_SAT_POS : // [R20]
                     (CUR_RAW < batmon_pkg::CUR_RAW_MIN) ? batmon_pkg::CUR_SAT_NEG : CUR_RAW[15:0];
  assign acr_sum_c = $signed({2'b00, acr_ff}) + $signed({{2{cur_ff[15]}}, cur_ff});

  // Results are only stored while active. [R01] [R03] [R18]
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      temp_ff <= 16'h0000;
      volt_ff <= 16'h0000;
    end else if (tick_ff && active_ff) begin
      temp_ff <= {TEMP_RAW, 5'h00}; // [R14] [R19]
      if (VOLT_RAW > batmon_pkg::VOLT_RAW_MAX) begin
        volt_ff <= batmon_pkg::VOLT_SAT; // [R10]
      end else begin
        volt_ff <= {1'b0, VOLT_RAW[9:0], 5'h00}; // [R07] [R08] [R09]
      end
    end
  end

  // Accumulation trails the current update by one cycle; a host write wins.
  logic acc_pend_ff;

  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      cur_ff <= 16'h0000;
      acc_pend_ff <= 1'b0;
    end else begin
      acc_pend_ff <= CUR_DONE && active_ff;
      if (CUR_DONE && active_ff) begin
        cur_ff <= cur_sat_c; // [R12] [R20]
      end
    end
  end

  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      acr_ff <= 16'h0000;
    end else if (acr_wr_c) begin
      acr_ff <= req_wdata_ff;
    end else if (acc_pend_ff && active_ff) begin
      if (acr_sum_c < 0) begin
        acr_ff <= batmon_pkg::ACR_MIN; // [R13]
      end else if (acr_sum_c[16]) begin
        acr_ff <= batmon_pkg::ACR_MAX;
      end else begin
        acr_ff <= acr_sum_c[15:0]; // [R13]
      end
    end
  end

  // The first voltage after reset or a charge write carries the invalid flag.
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      vpend_ff <= 1'b1;
      vinv_ff <= 1'b1;
    end else begin
      if (tick_ff && active_ff) begin
        vinv_ff <= vpend_ff; // [R11]
        vpend_ff <= 1'b0;
      end
      if (acr_wr_c) begin
        vpend_ff <= 1'b1; // [R11]
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  AST_SLEEP_ENTRY: assert property (@(posedge MCLK) disable iff (!RESET_N) // [R05]
    active_ff && sleep_en_ff && bus_low_c && slp_cnt_ff == SLEEP_CYC - 1'b1 |=> !active_ff)
    else $error("Sleep not entered after timeout.");

  AST_NO_EARLY_SLEEP: assert property (@(posedge MCLK) disable iff (!RESET_N) // [R05]
    active_ff && !(sleep_en_ff && bus_low_c) |=> active_ff && slp_cnt_ff == '0)
    else $error("Sleep counted without cause.");

  AST_WAKE: assert property (@(posedge MCLK) disable iff (!RESET_N) // [R21]
    !active_ff && !bus_low_c |=> active_ff ##1 ACTIVE)
    else $error("Line high did not wake the device.");

  AST_SLEEP_FROZEN: assert property (@(posedge MCLK) disable iff (!RESET_N) // [R03] [R18]
    !active_ff && !acr_wr_c |=> $stable(acr_ff) && $stable(cur_ff) && $stable(volt_ff) && $stable(temp_ff))
    else $error("Result changed while asleep.");

  AST_CUR_SAT_POS: assert property (@(posedge MCLK) disable iff (!RESET_N) // [R20]
    active_ff && CUR_DONE && CUR_RAW > batmon_pkg::CUR_RAW_MAX |=> cur_ff == batmon_pkg::CUR_SAT_POS)
    else $error("Charge current not saturated.");

  AST_CUR_SAT_NEG: assert property (@(posedge MCLK) disable iff (!RESET_N) // [R20]
    active_ff && CUR_DONE && CUR_RAW < batmon_pkg::CUR_RAW_MIN |=> cur_ff == batmon_pkg::CUR_SAT_NEG)
    else $error("Discharge current not saturated.");

  AST_VOLT_SAT: assert property (@(posedge MCLK) disable iff (!RESET_N) // [R10]
    active_ff && tick_ff && VOLT_RAW > batmon_pkg::VOLT_RAW_MAX |=> volt_ff == batmon_pkg::VOLT_SAT)
    else $error("Voltage not saturated.");

  AST_ACR_ADD: assert property (@(posedge MCLK) disable iff (!RESET_N) // [R13]
    active_ff && acc_pend_ff && !acr_wr_c && !acr_sum_c[17] && !acr_sum_c[16]
    |=> acr_ff == $past(acr_sum_c[15:0]))
    else $error("Charge accumulator did not add the current.");

  AST_VOLT_INVALID: assert property (@(posedge MCLK) disable iff (!RESET_N) // [R11]
    tick_ff && active_ff |=> vinv_ff == $past(vpend_ff))
    else $error("Voltage invalid flag not taken from the armed state.");

  AST_TICK_PERIOD: assert property (@(posedge MCLK) disable iff (!RESET_N) // [R07]
    tick_ff |-> tb_cnt_ff == '0 && $past(tb_cnt_ff) == MEAS_CYC - 1'b1)
    else $error("Measurement tick off its period.");

  AST_PIO_OPEN_DRAIN: assert property (@(posedge MCLK) disable iff (!RESET_N) // [R17]
    1'b1 |=> !PIO_O && PIO_OE == $past(pio_drv_ff))
    else $error("Pin driven other than low.");

endmodule : batmon

// >>> bench/i2c_host.sv
`timescale 1ns/100ps
module i2c_host (
  // Clock
  input wire logic clk,
  // Bus lines
  input wire logic sda_i,
  output logic scl,
  output logic sda_lo
);
  initial begin
    scl = 1'b1;
    sda_lo = 1'b0;
  end
  // A quarter bit of 33 clocks keeps both lines low far below the sleep timeout.
  task automatic q();
    repeat (33) @(posedge clk);
  endtask : q
  task automatic bitx(input logic b, output logic r);
    sda_lo <= !b;
    q();
    scl <= 1'b1;
    q();
    r = sda_i;
    q();
    scl <= 1'b0;
    q();
  endtask : bitx
  task automatic start();
    sda_lo <= 1'b0;
    q();
    scl <= 1'b1;
    q();
    sda_lo <= 1'b1;
    q();
    scl <= 1'b0;
    q();
  endtask : start
  task automatic stop();
    sda_lo <= 1'b1;
    q();
    scl <= 1'b1;
    q();
    sda_lo <= 1'b0;
    q();
  endtask : stop
  task automatic xfer(input logic [7:0] d, input logic a, output logic [7:0] r, inout logic nk);
    logic k;
    for (int i = 7; i >= 0; i--) bitx(d[i], r[i]);
    bitx(a, k);
    nk = nk | k;
  endtask : xfer
  // The slave address is an argument so that a reprogrammed address can be used.
  task automatic wr(input logic [6:0] a, input logic [7:0] p, input logic [15:0] w, output logic nk);
    logic [7:0] r;
    nk = 1'b0;
    start();
    xfer({a, 1'b0}, 1'b1, r, nk);
    xfer(p, 1'b1, r, nk);
    xfer(w[15:8], 1'b1, r, nk);
    xfer(w[7:0], 1'b1, r, nk);
    stop();
  endtask : wr
  task automatic rd(input logic [6:0] a, input logic [7:0] p, input int n, output logic [31:0] d, output logic nk);
    logic [7:0] r;
    logic x;
    nk = 1'b0;
    d = '0;
    start();
    xfer({a, 1'b0}, 1'b1, r, nk);
    xfer(p, 1'b1, r, nk);
    start();
    xfer({a, 1'b1}, 1'b1, r, nk);
    for (int i = 1; i <= 2 * n; i++) begin
      xfer(8'hff, i == 2 * n, r, x);
      d = {d[23:0], r};
    end
    stop();
  endtask : rd
  task automatic hold();
    scl <= 1'b0;
    sda_lo <= 1'b1;
  endtask : hold
  task automatic wake();
    scl <= 1'b1;
    q();
    sda_lo <= 1'b0;
  endtask : wake
endmodule : i2c_host

// >>> bench/battery_monitor_power_modes_tb.sv
`timescale 1ns/100ps
module battery_monitor_power_modes_tb;
  localparam logic [6:0] a0 = batmon_pkg::SLAVE_ADDR_RST;
  localparam logic [31:0] st_fresh = 32'(1 << batmon_pkg::ST_ACTIVE | 1 << batmon_pkg::ST_VOLT_INV
    | 1 << batmon_pkg::ST_PIO_SENSE);
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic link_clk = 1'b0;
  logic cur_done = 1'b0;
  logic signed [17:0] cur_raw = '0;
  logic [11:0] volt_raw = '0;
  logic [10:0] temp_raw = '0;
  logic scl, sda_lo, sda_oe, pio_i, pio_oe, active, sda, nk, sda_o, pio_o;
  logic [31:0] rnd = 32'hce254963;
  logic [31:0] got;
  int err_total = 0, checks_done = 0, cyc = 0, m_cur = 0, m_acr = 0;
  always #10 mclk = ~mclk;
  initial begin
    #13;
    forever #40 link_clk = ~link_clk;
  end
  // The data line is pulled up on the bus and the host drives the clock; the pin has a pull-up too.
  assign sda = !(sda_lo || sda_oe);
  assign pio_i = !pio_oe;
  i2c_host host_u (.clk(mclk), .sda_i(sda), .scl(scl), .sda_lo(sda_lo));
  batmon #(.MEAS_CYC(27'h2ee0), .SLEEP_CYC(27'h1f4)) dut_u (.MCLK(mclk), .RESET_N(reset_n), .LINK_CLK(link_clk),
    .SCL_I(scl), .SDA_I(sda), .SDA_O(sda_o), .SDA_OE(sda_oe), .PIO_I(pio_i), .PIO_O(pio_o), .PIO_OE(pio_oe),
    .CUR_RAW(cur_raw), .CUR_DONE(cur_done), .VOLT_RAW(volt_raw), .TEMP_RAW(temp_raw), .ACTIVE(active));
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      err_total++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic end_sim();
    if (err_total == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : end_sim
  task automatic to(input int n);
    while (cyc < n) @(posedge mclk);
  endtask : to
  task automatic rdc(input logic [6:0] a, input logic [7:0] p, input int n, input logic [31:0] e);
    host_u.rd(a, p, n, got, nk);
    chk({31'h0, nk}, 32'h0);
    chk(got, e);
  endtask : rdc
  task automatic pulse(input logic signed [17:0] r, input bit live);
    @(posedge mclk);
    cur_raw <= r;
    cur_done <= 1'b1;
    @(posedge mclk);
    cur_done <= 1'b0;
    repeat (4) @(posedge mclk);
    if (live) begin
      m_cur = r > 32767 ? 32767 : r < -32768 ? -32768 : int'(r);
      m_acr = m_acr + m_cur < 0 ? 0 : m_acr + m_cur > 65535 ? 65535 : m_acr + m_cur;
    end
  endtask : pulse
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 100000) begin
      err_total++;
      end_sim();
    end
  end
  initial begin
    repeat (16) @(posedge mclk);
    reset_n <= 1'b1;
    volt_raw <= 12'(rnd[9:0]);
    temp_raw <= rnd[26:16];
    repeat (8) @(posedge mclk);
    rdc(a0, 8'h00, 1, st_fresh);
    to(12600);
    rdc(a0, 8'h02, 2, {temp_raw, 5'h00, 1'b0, volt_raw[9:0], 5'h00});
    rnd = lfsr(rnd);
    volt_raw <= 12'h400 | rnd[11:0];
    to(24600);
    rdc(a0, 8'h04, 1, 32'h7fff);
    to(37000);
    host_u.wr(a0, 8'h08, 16'h1234, nk);
    chk({31'h0, nk}, 32'h0);
    m_acr = 32'h1234;
    for (int i = 0; i < 4; i++) begin
      rnd = lfsr(rnd);
      pulse(i == 2 ? 18'sh1ffff : i == 3 ? 18'sh20000 : 18'(signed'(rnd[15:0])), 1'b1);
    end
    // The host waits until just past the first result after the charge write.
    to(48600);
    rdc(a0, 8'h00, 1, st_fresh);
    rdc(a0, 8'h06, 2, {m_cur[15:0], m_acr[15:0]});
    host_u.wr(a0, 8'h0a, 16'h0033, nk);
    chk({31'h0, nk}, 32'h0);
    host_u.wr(a0, 8'h08, 16'hdead, nk);
    chk({31'h0, nk}, 32'h1);
    host_u.wr(7'h33, 8'h00, 16'h0003, nk);
    chk({28'h0, nk, pio_oe, pio_i, pio_o | sda_o}, 32'h4);
    host_u.hold();
    repeat (600) @(posedge mclk);
    chk({31'h0, active}, 32'h0);
    pulse(18'sh00100, 1'b0);
    host_u.wake();
    repeat (10) @(posedge mclk);
    chk({31'h0, active}, 32'h1);
    rdc(7'h33, 8'h06, 2, {m_cur[15:0], m_acr[15:0]});
    end_sim();
  end
endmodule : battery_monitor_power_modes_tb
